// file: isnt_cfg.svh
// Constants of the input scaling and oscillator tuner channel front end.
// Assumes a plain register port with 8-bit address and 16-bit data.
//
// Functional notes
// - Each port takes 14-bit signed mantissa, 3-bit range code and qualify.
// - Both input ports are sampled by the single master clock.
// - Active or inactive 5-bit scale adjusts range code, chosen by level.
// - Invert set, weighting clear: shift right by (7 - code + scale) mod 32.
// - Invert and weighting clear: each larger range code shifts mantissa one more bit right.
// - Invert set: a larger range code shifts data up relative to smaller one.
// - Exponent offset is added inside the mod-32 shift, shifting data down.
// - Independent 32-bit complex oscillator with two multipliers per channel.
// - Tuning word over two registers is a 32-bit unsigned phase increment.
// - Tuning word writes land in a shadow, moved on sleep exit or sync hop.
// - Event loads 16-bit hold-off counter; word moves when it reaches zero.
// - Immediate sync skips the hold-off countdown and applies the word.
// - 16-bit unsigned phase offset is added to the phase accumulator.
// - Oscillator control register is kept separately for this channel.
// - Level indicator from threshold detector selects the active gain scale.
// - Scale register: inactive scale in bits 9:5, active scale in bits 4:0.
`ifndef ISNT_CFG_SVH
`define ISNT_CFG_SVH

`define ISNT_ADDR_HOLDOFF 8'h84
`define ISNT_ADDR_TUNE_LO 8'h85
`define ISNT_ADDR_TUNE_HI 8'h86
`define ISNT_ADDR_PHASE_OFF 8'h87
`define ISNT_ADDR_OSC_CTRL 8'h88
`define ISNT_ADDR_STATUS 8'h89
`define ISNT_ADDR_COUNT 8'h8a
`define ISNT_ADDR_GAIN 8'h92

`define ISNT_CTRL_BYPASS 0
`define ISNT_CTRL_PDITHER 1
`define ISNT_CTRL_ADITHER 2
`define ISNT_CTRL_CLRHOP 3
`define ISNT_CTRL_QMODE_LO 4
`define ISNT_CTRL_PORTSEL 6
`define ISNT_CTRL_SYNCSEL_LO 7
`define ISNT_CTRL_IMMED 9

`define ISNT_GAIN_ACTIVE_LO 0
`define ISNT_GAIN_INACTIVE_LO 5
`define ISNT_GAIN_INVERT 10
`define ISNT_GAIN_WEIGHT 11

`define ISNT_REG_RESET 16'h0000
`define ISNT_EXP_BASE 5'h07
`define ISNT_LFSR_SEED 16'hace1
`define ISNT_PIPE_LAT 3

`endif

// file: isnt_pkg.sv
// Types shared by the tuner channel files.
// Assumes nothing beyond a SystemVerilog compiler.
package isnt_pkg;

  typedef struct packed {
    logic signed [13:0] mant;
    logic [2:0] range_code_in;
    logic sample_qualify;
  } isnt_port_s;

  typedef struct packed {
    logic signed [15:0] i_val;
    logic signed [15:0] q_val;
  } isnt_iq_s;

  typedef enum logic [1:0] {
    QM_BLANK = 2'b00,
    QM_LEVEL = 2'b01,
    QM_RISE = 2'b10,
    QM_FALL = 2'b11
  } isnt_qmode_e;

endpackage : isnt_pkg

// file: isnt_mixer.sv
// Sine and cosine lookup with the two mixing multipliers.
// Assumes a registered phase and sample from the tuner on the same clock.
`timescale 1ns/1ns
`default_nettype none

module isnt_mixer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [15:0] phase_i,
  input wire logic signed [13:0] sample_i,
  input wire logic amp_dither_i,
  input wire logic dither_bit_i,
  output isnt_pkg::isnt_iq_s iq_o
);
  import isnt_pkg::*;

  // Quarter wave, 16 steps; coarse on purpose to keep the table small
  function automatic logic [15:0] quarter(input logic [4:0] idx);
    unique case (idx)
      5'h00: quarter = 16'h0000;
      5'h01: quarter = 16'h0c8c;
      5'h02: quarter = 16'h18f9;
      5'h03: quarter = 16'h2528;
      5'h04: quarter = 16'h30fb;
      5'h05: quarter = 16'h3c56;
      5'h06: quarter = 16'h471c;
      5'h07: quarter = 16'h5133;
      5'h08: quarter = 16'h5a82;
      5'h09: quarter = 16'h62f1;
      5'h0a: quarter = 16'h6a6d;
      5'h0b: quarter = 16'h70e2;
      5'h0c: quarter = 16'h7641;
      5'h0d: quarter = 16'h7a7c;
      5'h0e: quarter = 16'h7d89;
      5'h0f: quarter = 16'h7f61;
      default: quarter = 16'h7fff;
    endcase
  endfunction : quarter

  function automatic logic signed [15:0] sine(input logic [5:0] p);
    logic [15:0] mag;
    mag = p[4] ? quarter(5'h10 - {1'b0, p[3:0]}) : quarter({1'b0, p[3:0]});
    sine = p[5] ? -$signed(mag) : $signed(mag);
  endfunction : sine

  logic signed [15:0] cos_v;
  logic signed [15:0] nsin_v;
  logic signed [29:0] prod_i;
  logic signed [29:0] prod_q;

  always_comb begin
    cos_v = sine(phase_i[15:10] + 6'h10);
    nsin_v = -sine(phase_i[15:10]);
    // Amplitude dither breaks up the quantisation pattern of the table
    if (amp_dither_i) begin
      cos_v[0] = cos_v[0] ^ dither_bit_i;
      nsin_v[0] = nsin_v[0] ^ dither_bit_i;
    end
    prod_i = sample_i * cos_v;
    prod_q = sample_i * nsin_v;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      iq_o <= '0;
    end else begin
      iq_o.i_val <= prod_i[29:14];
      iq_o.q_val <= prod_q[29:14];
    end
  end

endmodule : isnt_mixer

`default_nettype wire

// file: isnt_tuner.sv
// Channel front end: input port select, range-code scaling and NCO tuning.
// Assumes converters, level detector and sync sources run on clock_i.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "isnt_cfg.svh"

module isnt_tuner (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire isnt_pkg::isnt_port_s port_a_i,
  input wire isnt_pkg::isnt_port_s port_b_i,
  input wire logic level_indicator_i,
  input wire logic sleep_exit_i,
  input wire logic [3:0] sync_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  output isnt_pkg::isnt_iq_s iq_o,
  output logic iq_valid_o
);
  import isnt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0] holdoff_reg;
  logic [31:0] shadow_reg;
  logic [31:0] active_reg;
  logic [15:0] phase_off_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] gain_reg;
  logic [15:0] count_reg;
  logic run_reg;
  logic hop_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      holdoff_reg <= `ISNT_REG_RESET;
      shadow_reg <= {`ISNT_REG_RESET, `ISNT_REG_RESET};
      phase_off_reg <= `ISNT_REG_RESET;
      ctrl_reg <= `ISNT_REG_RESET;
      gain_reg <= `ISNT_REG_RESET;
    end else if (wr_i) begin
      unique case (addr_i)
        `ISNT_ADDR_HOLDOFF: holdoff_reg <= wr_data_i;
        `ISNT_ADDR_TUNE_LO: shadow_reg[15:0] <= wr_data_i;
        `ISNT_ADDR_TUNE_HI: shadow_reg[31:16] <= wr_data_i;
        `ISNT_ADDR_PHASE_OFF: phase_off_reg <= wr_data_i;
        `ISNT_ADDR_OSC_CTRL: ctrl_reg <= wr_data_i;
        `ISNT_ADDR_GAIN: gain_reg <= wr_data_i;
        default: ;
      endcase
    end
  end

  // Data only in the cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `ISNT_ADDR_HOLDOFF: rd_data_o <= holdoff_reg;
        `ISNT_ADDR_TUNE_LO: rd_data_o <= shadow_reg[15:0];
        `ISNT_ADDR_TUNE_HI: rd_data_o <= shadow_reg[31:16];
        `ISNT_ADDR_PHASE_OFF: rd_data_o <= phase_off_reg;
        `ISNT_ADDR_OSC_CTRL: rd_data_o <= ctrl_reg;
        `ISNT_ADDR_STATUS: rd_data_o <= {14'h0000, level_indicator_i, run_reg};
        `ISNT_ADDR_COUNT: rd_data_o <= count_reg;
        `ISNT_ADDR_GAIN: rd_data_o <= gain_reg;
        default: rd_data_o <= 16'h0000;
      endcase
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input ports and sample qualification

  isnt_port_s in_a_reg;
  isnt_port_s in_b_reg;
  isnt_port_s sel;
  logic qual_prev_reg;
  logic proc_next;
  isnt_qmode_e qmode;

  // Converters share clock_i, so one capture register is enough
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      in_a_reg <= '0;
      in_b_reg <= '0;
      qual_prev_reg <= 1'b0;
    end else begin
      in_a_reg <= port_a_i;
      in_b_reg <= port_b_i;
      qual_prev_reg <= sel.sample_qualify;
    end
  end

  always_comb begin
    sel = ctrl_reg[`ISNT_CTRL_PORTSEL] ? in_b_reg : in_a_reg;
    qmode = isnt_qmode_e'(ctrl_reg[`ISNT_CTRL_QMODE_LO +: 2]);
    unique case (qmode)
      QM_BLANK: proc_next = 1'b1;
      QM_LEVEL: proc_next = sel.sample_qualify;
      QM_RISE: proc_next = sel.sample_qualify & ~qual_prev_reg;
      QM_FALL: proc_next = ~sel.sample_qualify & qual_prev_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Range-code scaling

  function automatic logic [4:0] shift_of(input logic [2:0] code,
                                          input logic [15:0] gain,
                                          input logic loud);
    logic [4:0] scale;
    logic [4:0] e;
    scale = loud ? gain[`ISNT_GAIN_ACTIVE_LO +: 5]
                 : gain[`ISNT_GAIN_INACTIVE_LO +: 5];
    e = gain[`ISNT_GAIN_WEIGHT] ? {1'b0, code, 1'b0} : {2'b00, code};
    // Five-bit sums wrap, which gives the mod-32 behaviour
    if (gain[`ISNT_GAIN_INVERT]) begin
      shift_of = `ISNT_EXP_BASE - e + scale;
    end else begin
      shift_of = e + scale;
    end
  endfunction : shift_of

  function automatic logic signed [13:0] scaled(input isnt_port_s p,
                                                input logic [4:0] sh);
    scaled = p.mant >>> sh;
  endfunction : scaled

  logic [4:0] shift_sel;
  logic [4:0] shift_b;
  logic blank;
  logic signed [13:0] samp_reg;
  logic signed [13:0] samp_b_reg;
  logic [4:0] shift_reg;
  logic s1_valid_reg;

  always_comb begin
    shift_sel = shift_of(sel.range_code_in, gain_reg,
                         level_indicator_i);
    shift_b = shift_of(in_b_reg.range_code_in, gain_reg, level_indicator_i);
    blank = (qmode == QM_BLANK) && !sel.sample_qualify;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      samp_reg <= 14'h0000;
      samp_b_reg <= 14'h0000;
      shift_reg <= 5'h00;
      s1_valid_reg <= 1'b0;
    end else begin
      shift_reg <= shift_sel;
      s1_valid_reg <= proc_next;
      if (ctrl_reg[`ISNT_CTRL_BYPASS]) begin
        samp_reg <= scaled(in_a_reg, shift_of(in_a_reg.range_code_in,
                                              gain_reg, level_indicator_i));
        samp_b_reg <= scaled(in_b_reg, shift_b);
      end else begin
        samp_reg <= blank ? 14'h0000 : scaled(sel, shift_sel);
        samp_b_reg <= 14'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tuning word shadow and hold-off

  logic hop;
  logic xfer_event;
  logic transfer;
  logic clear_now;

  always_comb begin
    hop = sync_i[ctrl_reg[`ISNT_CTRL_SYNCSEL_LO +: 2]];
    xfer_event = sleep_exit_i | hop;
    // A fresh event restarts the count rather than completing the old one
    transfer = xfer_event ? ctrl_reg[`ISNT_CTRL_IMMED]
                          : (run_reg && count_reg == 16'h0000);
    clear_now = transfer & ctrl_reg[`ISNT_CTRL_CLRHOP]
              & (xfer_event ? hop : hop_reg);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
      count_reg <= 16'h0000;
      hop_reg <= 1'b0;
    end else if (xfer_event) begin
      run_reg <= ~ctrl_reg[`ISNT_CTRL_IMMED];
      count_reg <= holdoff_reg;
      hop_reg <= hop;
    end else if (run_reg) begin
      if (count_reg == 16'h0000) begin
        run_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      active_reg <= 32'h0000_0000;
    end else if (transfer) begin
      active_reg <= shadow_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase accumulator, dither and mixing

  logic [31:0] acc_reg;
  logic [15:0] lfsr_reg;
  logic [15:0] phase_reg;
  logic [31:0] dithered;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc_reg <= 32'h0000_0000;
    end else if (clear_now) begin
      acc_reg <= 32'h0000_0000;
    end else if (proc_next) begin
      acc_reg <= acc_reg + active_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lfsr_reg <= `ISNT_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  always_comb begin
    dithered = acc_reg
             + (ctrl_reg[`ISNT_CTRL_PDITHER] ? {16'h0000, lfsr_reg}
                                              : 32'h0000_0000);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_reg <= 16'h0000;
    end else begin
      phase_reg <= dithered[31:16] + phase_off_reg;
    end
  end

  isnt_iq_s mix;
  logic signed [13:0] byp_i_reg;
  logic signed [13:0] byp_q_reg;
  logic s2_valid_reg;

  isnt_mixer u_mixer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .phase_i(phase_reg),
    .sample_i(samp_reg),
    .amp_dither_i(ctrl_reg[`ISNT_CTRL_ADITHER]),
    .dither_bit_i(lfsr_reg[15]),
    .iq_o(mix)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      byp_i_reg <= 14'h0000;
      byp_q_reg <= 14'h0000;
      s2_valid_reg <= 1'b0;
      iq_o <= '0;
      iq_valid_o <= 1'b0;
    end else begin
      byp_i_reg <= samp_reg;
      byp_q_reg <= samp_b_reg;
      s2_valid_reg <= s1_valid_reg;
      iq_valid_o <= s2_valid_reg;
      // Bypass trades tuning for a complex path: port A as I, port B as Q
      if (ctrl_reg[`ISNT_CTRL_BYPASS]) begin
        iq_o.i_val <= {byp_i_reg, 2'b00};
        iq_o.q_val <= {byp_q_reg, 2'b00};
      end else begin
        iq_o <= mix;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  shift_invert_a: assert property (
    sel.sample_qualify && gain_reg[`ISNT_GAIN_INVERT]
    && !gain_reg[`ISNT_GAIN_WEIGHT] && level_indicator_i && $stable(gain_reg)
    |=> shift_reg == 5'(`ISNT_EXP_BASE - {2'b00, $past(sel.range_code_in)}
                        + $past(gain_reg[4:0])))
    else $error("inverted shift amount wrong");

  shift_plain_a: assert property (
    !gain_reg[`ISNT_GAIN_INVERT] && !gain_reg[`ISNT_GAIN_WEIGHT]
    && !level_indicator_i && $stable(gain_reg)
    |=> shift_reg == 5'({2'b00, $past(sel.range_code_in)}
                        + $past(gain_reg[9:5])))
    else $error("plain shift amount wrong");

  shadow_hold_a: assert property (
    !xfer_event && !run_reg |=> active_reg == $past(active_reg))
    else $error("tuning word moved without event");

  holdoff_load_a: assert property (
    xfer_event && !ctrl_reg[`ISNT_CTRL_IMMED]
    |=> run_reg && count_reg == $past(holdoff_reg))
    else $error("hold-off count not loaded");

  holdoff_end_a: assert property (
    run_reg && count_reg == 16'h0000 && !xfer_event
    |=> !run_reg && active_reg == $past(shadow_reg))
    else $error("word not applied at zero count");

  immed_sync_a: assert property (
    xfer_event && ctrl_reg[`ISNT_CTRL_IMMED]
    |=> !run_reg && active_reg == $past(shadow_reg))
    else $error("immediate sync not applied");

  acc_step_a: assert property (
    proc_next && !clear_now
    |=> acc_reg == $past(acc_reg) + $past(active_reg))
    else $error("accumulator step wrong");

  phase_sum_a: assert property (
    !ctrl_reg[`ISNT_CTRL_PDITHER] && $stable(ctrl_reg)
    |=> phase_reg == $past(acc_reg[31:16]) + $past(phase_off_reg))
    else $error("phase offset not applied");

  valid_lat_a: assert property (
    proc_next |-> ##`ISNT_PIPE_LAT iq_valid_o)
    else $error("output valid latency wrong");

  read_back_a: assert property (
    rd_i && addr_i == `ISNT_ADDR_OSC_CTRL |=> rd_data_o == $past(ctrl_reg))
    else $error("control read back wrong");

  cov_immed_c: cover property (xfer_event && ctrl_reg[`ISNT_CTRL_IMMED]);
  cov_holdoff_c: cover property (run_reg && count_reg == 16'h0000);
  cov_rise_c: cover property (qmode == QM_RISE && proc_next);
  cov_bypass_c: cover property (ctrl_reg[`ISNT_CTRL_BYPASS] && iq_valid_o);

endmodule : isnt_tuner

`default_nettype wire

// file: isnt_adc_model.sv
// Converter pair model that feeds both input ports of the tuner.
// Assumes the bench changes its inputs just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module isnt_adc_model #(
  parameter int ADC_BITS = 12,
  parameter bit FIXED_POINT = 1'b0
) (
  input wire logic signed [ADC_BITS-1:0] raw_a_i,
  input wire logic signed [ADC_BITS-1:0] raw_b_i,
  input wire logic [2:0] code_a_i,
  input wire logic [2:0] code_b_i,
  input wire logic qual_a_i,
  input wire logic qual_b_i,
  output wire isnt_pkg::isnt_port_s port_a_o,
  output wire isnt_pkg::isnt_port_s port_b_o
);
  import isnt_pkg::*;
  localparam int PAD = 14 - ADC_BITS;
  //////////////////////////////////////////////////////////////////////////
  // Narrow part sits on the top bits; spare low bits held low, never floated
  // Fixed-point parts have no range code, so those pins are tied low
  assign port_a_o = '{mant: {raw_a_i, {PAD{1'b0}}},
                      range_code_in: FIXED_POINT ? 3'h0 : code_a_i,
                      sample_qualify: qual_a_i};
  assign port_b_o = '{mant: {raw_b_i, {PAD{1'b0}}},
                      range_code_in: FIXED_POINT ? 3'h0 : code_b_i,
                      sample_qualify: qual_b_i};
endmodule : isnt_adc_model
`default_nettype wire

// file: isnt_tuner_tb.sv
// Self-checking bench of the tuner channel front end.
// Assumes the converter model, the tuner and its package.
`timescale 1ns/1ns
`default_nettype none

module isnt_tuner_tb;
  import isnt_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic signed [11:0] raw_a = 12'h000, raw_b = 12'h000;
  logic [2:0] code_a = 3'h0, code_b = 3'h0;
  logic qual_a = 1'b0, qual_b = 1'b0, li = 1'b0, slp = 1'b0;
  logic [3:0] sync = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdat = 16'h0000, rdat, rdq;
  logic wr = 1'b0, rd = 1'b0, iq_valid, strict = 1'b0;
  isnt_port_s pa, pb;
  isnt_iq_s iq;
  int n_fail = 0, check_count = 0, cyc = 0, nz;
  logic [31:0] lfsr = 32'hb5522416;
  logic [63:0] expq[$];
  logic [7:0] rmap[8] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h92,
                          8'h89, 8'h8a};
  logic [15:0] gtab[3] = '{16'h07de, 16'h0000, 16'h0c21};

  isnt_adc_model #(.ADC_BITS(12), .FIXED_POINT(1'b0)) conv (
    .raw_a_i(raw_a), .raw_b_i(raw_b), .code_a_i(code_a), .code_b_i(code_b),
    .qual_a_i(qual_a), .qual_b_i(qual_b), .port_a_o(pa), .port_b_o(pb));
  isnt_tuner dut (.clock_i(clock_i), .rst_i(rst_i), .port_a_i(pa),
    .port_b_i(pb), .level_indicator_i(li), .sleep_exit_i(slp),
    .sync_i(sync), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdat), .iq_o(iq), .iq_valid_o(iq_valid));

  always #2 clock_i = ~clock_i;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Shift wraps at 32 like the hardware, so large offsets stay legal
  function automatic logic [15:0] scl(input logic [11:0] raw,
      input logic [2:0] c, input logic [15:0] g, input logic lv);
    logic [4:0] e, sc, s;
    logic signed [13:0] m;
    e = g[11] ? {1'b0, c, 1'b0} : {2'h0, c};
    sc = lv ? g[4:0] : g[9:5];
    s = g[10] ? 5'h07 - e + sc : e + sc;
    m = $signed({raw, 2'h0}) >>> s;
    return {m, 2'h0};
  endfunction : scl

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // Read data captured at the closing edge, before it drops back to zero
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [15:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= d;
    @(posedge clock_i);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock_i);
    rdq = rdat;
  endtask : bus

  // Status is read every cycle so the hold-off length is counted exactly
  task automatic hop(input logic se, input logic [3:0] y, input int exp);
    int ones;
    slp <= se;
    sync <= y;
    @(posedge clock_i);
    slp <= 1'b0;
    sync <= 4'h0;
    rd <= 1'b1;
    addr <= 8'h89;
    ones = 0;
    repeat (40) begin
      @(posedge clock_i);
      if (rdat[0] === 1'b1)
        ones++;
    end
    rd <= 1'b0;
    chk(16'(ones), 16'(exp));
  endtask : hop

  task automatic count_nz();
    repeat (8) @(posedge clock_i);
    nz = 0;
    repeat (24) begin
      @(posedge clock_i);
      if (iq.q_val !== 16'h0000)
        nz++;
    end
  endtask : count_nz

  task automatic batch(input logic [1:0] mode, input logic [15:0] g,
      input logic lv, input logic sel);
    logic q, prev, take;
    logic [31:0] r;
    strict = 1'b0;
    prev = 1'b0;
    li <= lv;
    // Both quals low first, so the edge modes start from a known level
    qual_a <= 1'b0;
    qual_b <= 1'b0;
    bus(1'b1, 8'h92, g);
    bus(1'b1, 8'h88, {9'h000, sel, mode, 4'h1});
    repeat (8) @(posedge clock_i);
    strict = (mode != 2'h0);
    for (int k = 0; k < 32; k++) begin
      r = rnd();
      q = (mode == 2'h0) || (k < 24 && r[30]);
      take = mode == 2'h0 ? 1'b1 : mode == 2'h1 ? q :
             mode == 2'h2 ? q & !prev : !q & prev;
      prev = q;
      raw_a <= r[11:0];
      raw_b <= r[23:12];
      code_a <= r[26:24];
      code_b <= r[29:27];
      qual_a <= sel ? r[31] : q;
      qual_b <= sel ? q : r[31];
      if (take)
        expq.push_back({32'(cyc + 5), scl(r[11:0], r[26:24], g, lv),
                        scl(r[23:12], r[29:27], g, lv)});
      @(posedge clock_i);
    end
    repeat (10) @(posedge clock_i);
    chk(16'(expq.size()), 16'h0000);
  endtask : batch
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (expq.size() > 0 && expq[0][63:32] == cyc) begin
      chk({15'h0000, iq_valid}, 16'h0001);
      chk(iq.i_val, expq[0][31:16]);
      chk(iq.q_val, expq[0][15:0]);
      void'(expq.pop_front());
    end else if (strict && iq_valid !== 1'b0)
      chk({15'h0000, iq_valid}, 16'h0000);
  end

  initial begin
    repeat (50000) @(posedge clock_i);
    n_fail++;
    test_done();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (rmap[k]) begin
      bus(1'b0, rmap[k], 16'h0000);
      chk(rdq, 16'h0000);
    end
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      bus(1'b1, rmap[k], r[15:0]);
      bus(1'b0, rmap[k], 16'h0000);
      chk(rdq, r[15:0]);
    end
    bus(1'b1, 8'h00, 16'hffff);
    bus(1'b0, 8'h00, 16'h0000);
    chk(rdq, 16'h0000);
    for (int b = 0; b < 12; b++) begin
      r = rnd();
      batch(2'(b), b < 3 ? gtab[b] : {4'h0, r[11:0]}, r[16],
            r[17]);
    end
    // Plain tone path, steady positive input, word still zero
    strict = 1'b0;
    bus(1'b1, 8'h92, 16'h0000);
    bus(1'b1, 8'h88, 16'h0000);
    raw_a <= 12'h400;
    code_a <= 3'h0;
    qual_a <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 8'h87, {k[1:0], 14'h0000});
      repeat (8) @(posedge clock_i);
      chk(k == 1 ? iq.i_val : iq.q_val, 16'h0000);
      chk({15'h0000, k == 1 ? iq.q_val[15] : iq.i_val[15]},
          {15'h0000, k != 0});
    end
    bus(1'b1, 8'h87, 16'h0000);
    bus(1'b1, 8'h84, 16'h0006);
    bus(1'b1, 8'h86, 16'h0100);
    count_nz();
    chk(16'(nz), 16'h0000);
    hop(1'b1, 4'h0, 7);
    count_nz();
    chk({15'h0000, nz == 0}, 16'h0000);
    bus(1'b1, 8'h88, 16'h0200);
    hop(1'b1, 4'h0, 0);
    bus(1'b1, 8'h84, 16'h0003);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h88, {7'h00, s[1:0], 7'h00});
      hop(1'b0, 4'h1 << ((s + 1) % 4), 0);
      hop(1'b0, 4'h1 << s, 4);
    end
    test_done();
  end
endmodule : isnt_tuner_tb
`default_nettype wire
